// ==== logic/hfbs_device.sv ====
// Host-controller frame scheduler: registers, ping-pong isochronous buffers,
// async descriptor list engine. Assumes a USB packet engine beside it that
// answers each USB_TX_START_OUT with one USB_TX_DONE_IN pulse.
`timescale 1ns/1ps
module hfbs_device #(
  parameter int FRAME_CYCLES = hfbs_pkg::FRAME_CYCLES,
  parameter int WORDS = hfbs_pkg::BUF_WORDS
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  hfbs_if.dev LINK,
  input wire logic USB_TX_DONE_IN,
  input wire logic USB_TX_ERR_IN,
  output logic USB_TX_START_OUT,
  output logic USB_TX_ISO_OUT,
  output logic USB_TX_LOWSPEED_OUT,
  output logic [9:0] USB_TX_LEN_OUT,
  output logic SOF_OUT,
  output logic INTERNAL_PULLDOWN_SEL_OUT
);
  localparam int AW = $clog2(WORDS);
  typedef enum logic [1:0] {ST_IDLE, ST_ISO_WAIT, ST_SCAN, ST_PKT_WAIT} hfbs_state_e;
  hfbs_state_e st_r;

  logic sreset_r;
  logic rst;
  logic [7:0] cmd_r;
  logic half_r;
  logic [15:0] ptr_r;
  logic [31:0] fm_interval_r, ls_thr_r;
  logic [15:0] hw_cfg_r, ctrl_r, xfer_cnt_r, iso_len_r, async_len_r, irq_r, rdata_r;
  logic [31:0] frame_cnt_r;
  logic [1:0] iso_full_r, iso_done_r, iso_stuck_r;
  logic iso_sel_r, iso_proc_r, iso_processed_r;
  logic [15:0] iso_bytes_r [2];
  logic async_full_r, async_done_r, async_run_r, quiet_irq_r, any_active_r;
  logic [AW-1:0] desc_cnt_r, desc_idx_r;
  logic [9:0] pkt_len_r;
  logic [15:0] iso_mem [2*WORDS];
  logic [15:0] async_mem [WORDS];

  logic [6:0] idx;
  logic is_wr, wr_acc, rd_acc, port_iso, port_async, eot, sof;
  logic iso_wbusy, async_wbusy, iso_go, async_fin, operational;
  logic [15:0] d0, d1, rd_mux;
  logic [9:0] need_len;
  logic [31:0] need_time;

  function automatic logic is_reg32(input logic [6:0] i);
    return i == hfbs_pkg::IDX_FRAME_INTERVAL || i == hfbs_pkg::IDX_LS_THRESHOLD;
  endfunction

  function automatic logic [15:0] half_of(input logic [31:0] v, input logic h);
    return h ? v[31:16] : v[15:0];
  endfunction

  assign rst = RST_IN | sreset_r;
  assign idx = cmd_r[6:0];
  assign is_wr = cmd_r[hfbs_pkg::CMD_WRITE_BIT];
  assign wr_acc = LINK.dat_we && is_wr;
  assign rd_acc = LINK.dat_re && !is_wr;
  assign port_iso = idx == hfbs_pkg::IDX_ISO_PORT;
  assign port_async = idx == hfbs_pkg::IDX_ASYNC_PORT;
  assign eot = (wr_acc || rd_acc) && (port_iso || port_async)
               && (ptr_r + 16'h0002 >= xfer_cnt_r);
  assign sof = frame_cnt_r == 32'h0;
  assign iso_wbusy = port_iso && is_wr && ptr_r != 16'h0;
  assign async_wbusy = port_async && is_wr && ptr_r != 16'h0;
  assign operational = ctrl_r[hfbs_pkg::CTRL_FUNC_LO +: 2] == hfbs_pkg::FUNC_OPERATIONAL;
  // A buffer awaiting its done flag or stuck is never sent again
  assign iso_go = sof && iso_full_r[iso_sel_r] && !iso_done_r[iso_sel_r]
                  && !iso_stuck_r[iso_sel_r] && !(iso_processed_r && iso_proc_r == iso_sel_r);
  assign d0 = async_mem[{desc_idx_r[AW-2:0], 1'b0}];
  assign d1 = async_mem[{desc_idx_r[AW-2:0], 1'b1}];
  assign need_len = (d1[9:0] != 10'h0 && d1[9:0] < d0[9:0]) ? d1[9:0] : d0[9:0];
  assign need_time = d1[hfbs_pkg::DESC_LS_BIT]
      ? {20'h0, ls_thr_r[hfbs_pkg::LS_FIELD_HI:0]}
      : {17'h0, fm_interval_r[hfbs_pkg::FS_FIELD_HI:hfbs_pkg::FS_FIELD_LO]};
  assign async_fin = st_r == ST_SCAN && desc_idx_r == desc_cnt_r && !any_active_r;

  always_comb begin
    unique case (idx)
      hfbs_pkg::IDX_CONTROL: rd_mux = ctrl_r;
      hfbs_pkg::IDX_FRAME_INTERVAL: rd_mux = half_of(fm_interval_r, half_r);
      hfbs_pkg::IDX_LS_THRESHOLD: rd_mux = half_of(ls_thr_r, half_r);
      hfbs_pkg::IDX_HW_CONFIG: rd_mux = hw_cfg_r;
      hfbs_pkg::IDX_TRANSFER_COUNT: rd_mux = xfer_cnt_r;
      hfbs_pkg::IDX_IRQ_FLAGS: rd_mux = irq_r;
      hfbs_pkg::IDX_ISO_LENGTH: rd_mux = iso_len_r;
      hfbs_pkg::IDX_ASYNC_LENGTH: rd_mux = async_len_r;
      hfbs_pkg::IDX_BUFFER_FLAGS: rd_mux = {10'h0, async_done_r, iso_done_r, async_full_r,
                                            iso_full_r};
      hfbs_pkg::IDX_ISO_PORT: rd_mux = iso_mem[{iso_sel_r, ptr_r[AW:1]}];
      hfbs_pkg::IDX_ASYNC_PORT: rd_mux = async_mem[ptr_r[AW:1]];
      default: rd_mux = 16'h0;
    endcase
  end

  // Command port, pointer and plain registers
  always_ff @(posedge CORE_CLK_IN) begin
    if (rst) begin
      cmd_r <= 8'h0;
      half_r <= 1'b0;
      ptr_r <= 16'h0;
      fm_interval_r <= 32'h0;
      ls_thr_r <= 32'h0;
      hw_cfg_r <= 16'h0;
      ctrl_r <= 16'h0;
      xfer_cnt_r <= 16'h0;
      iso_len_r <= 16'h0;
      async_len_r <= 16'h0;
      rdata_r <= 16'h0;
    end else begin
      if (LINK.dat_re) begin
        rdata_r <= is_wr ? 16'h0 : rd_mux;
      end
      if (LINK.cmd_we) begin
        cmd_r <= LINK.wdata[7:0];
        half_r <= 1'b0;
        ptr_r <= 16'h0;
      end else if (LINK.dat_we || LINK.dat_re) begin
        half_r <= is_reg32(idx) ? !half_r : 1'b0;
        if (port_iso || port_async) begin
          ptr_r <= eot ? 16'h0 : ptr_r + 16'h0002;
        end
      end
      if (wr_acc) begin
        unique case (idx)
          hfbs_pkg::IDX_CONTROL: ctrl_r <= LINK.wdata;
          hfbs_pkg::IDX_FRAME_INTERVAL: begin
            if (half_r) fm_interval_r[31:16] <= LINK.wdata;
            else fm_interval_r[15:0] <= LINK.wdata;
          end
          hfbs_pkg::IDX_LS_THRESHOLD: begin
            if (half_r) ls_thr_r[31:16] <= LINK.wdata;
            else ls_thr_r[15:0] <= LINK.wdata;
          end
          hfbs_pkg::IDX_HW_CONFIG: hw_cfg_r <= LINK.wdata;
          hfbs_pkg::IDX_TRANSFER_COUNT: xfer_cnt_r <= LINK.wdata;
          hfbs_pkg::IDX_ISO_LENGTH: iso_len_r <= LINK.wdata;
          hfbs_pkg::IDX_ASYNC_LENGTH: async_len_r <= LINK.wdata;
          default: ;
        endcase
      end
    end
  end

  // Soft reset is a one-cycle pulse so it releases itself
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) sreset_r <= 1'b0;
    else sreset_r <= wr_acc && idx == hfbs_pkg::IDX_SOFT_RESET
                     && LINK.wdata == hfbs_pkg::SOFT_RESET_KEY;
  end

  // Buffer memories; the engine writes back descriptor headers
  always_ff @(posedge CORE_CLK_IN) begin
    if (wr_acc && port_iso) iso_mem[{iso_sel_r, ptr_r[AW:1]}] <= LINK.wdata;
    if (wr_acc && port_async) begin
      async_mem[ptr_r[AW:1]] <= LINK.wdata;
    end else if (st_r == ST_PKT_WAIT && USB_TX_DONE_IN) begin
      async_mem[{desc_idx_r[AW-2:0], 1'b0}] <= {!(USB_TX_ERR_IN || d0[9:0] == pkt_len_r),
                                                5'h0, d0[9:0] - pkt_len_r};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (rst || sof) frame_cnt_r <= 32'(FRAME_CYCLES - 1);
    else frame_cnt_r <= frame_cnt_r - 32'h1;
  end

  // Isochronous ping-pong flags; the frame-start updates come last so they win
  always_ff @(posedge CORE_CLK_IN) begin
    if (rst) begin
      iso_full_r <= 2'h0;
      iso_done_r <= 2'h0;
      iso_stuck_r <= 2'h0;
      iso_sel_r <= 1'b0;
      iso_proc_r <= 1'b0;
      iso_processed_r <= 1'b0;
      iso_bytes_r <= '{16'h0, 16'h0};
    end else begin
      if (wr_acc && port_iso && eot) begin
        iso_full_r[iso_sel_r] <= 1'b1;
        iso_bytes_r[iso_sel_r] <= xfer_cnt_r;
      end
      if (rd_acc && port_iso && iso_done_r[iso_sel_r] && !iso_stuck_r[iso_sel_r]) begin
        iso_full_r[iso_sel_r] <= 1'b0;
        iso_done_r[iso_sel_r] <= 1'b0;
      end
      if (st_r == ST_ISO_WAIT && USB_TX_DONE_IN) iso_processed_r <= 1'b1;
      if (sof) begin
        for (int b = 0; b < 2; b++) begin
          if (iso_done_r[b]) begin
            iso_done_r[b] <= 1'b0;
            iso_stuck_r[b] <= 1'b1;
          end
        end
        if (iso_processed_r) begin
          iso_done_r[iso_proc_r] <= 1'b1;
          iso_processed_r <= 1'b0;
        end
        iso_sel_r <= (&iso_full_r) ? 1'b1 : !iso_sel_r;
        if (iso_go) iso_proc_r <= iso_sel_r;
      end
    end
  end

  // Async buffer status and frame-level scheduling decisions
  always_ff @(posedge CORE_CLK_IN) begin
    if (rst) begin
      async_full_r <= 1'b0;
      async_done_r <= 1'b0;
      async_run_r <= 1'b0;
      quiet_irq_r <= 1'b0;
      desc_cnt_r <= '0;
    end else begin
      if (wr_acc && port_async && eot) begin
        async_full_r <= 1'b1;
        async_done_r <= 1'b0;
        desc_cnt_r <= xfer_cnt_r[AW+1:2];
      end
      if (rd_acc && port_async && eot) begin
        async_full_r <= 1'b0;
        async_done_r <= 1'b0;
      end
      if (async_fin) async_done_r <= 1'b1;
      if (sof) begin
        async_run_r <= async_full_r && !async_done_r && operational && !async_wbusy;
        quiet_irq_r <= iso_wbusy || async_wbusy;
      end
    end
  end

  // Interrupt flags: write one to clear, hardware set wins
  always_ff @(posedge CORE_CLK_IN) begin
    if (rst) begin
      irq_r <= 16'h0;
    end else begin
      if (wr_acc && idx == hfbs_pkg::IDX_IRQ_FLAGS) irq_r <= irq_r & ~LINK.wdata;
      if (iso_go) irq_r[hfbs_pkg::IRQ_ISO_BIT] <= 1'b1;
      if (async_fin && !quiet_irq_r && operational) begin
        irq_r[hfbs_pkg::IRQ_ASYNC_BIT] <= 1'b1;
      end
      if (eot) irq_r[hfbs_pkg::IRQ_EOT_BIT] <= 1'b1;
    end
  end

  // Packet engine: isochronous packet first, then passes over the async list
  always_ff @(posedge CORE_CLK_IN) begin
    if (rst) begin
      st_r <= ST_IDLE;
      desc_idx_r <= '0;
      any_active_r <= 1'b0;
      pkt_len_r <= 10'h0;
      USB_TX_START_OUT <= 1'b0;
      USB_TX_ISO_OUT <= 1'b0;
      USB_TX_LOWSPEED_OUT <= 1'b0;
      USB_TX_LEN_OUT <= 10'h0;
    end else begin
      USB_TX_START_OUT <= 1'b0;
      unique case (st_r)
        ST_IDLE, ST_SCAN: begin
          if (sof) begin
            desc_idx_r <= '0;
            any_active_r <= 1'b0;
            if (iso_go) begin
              USB_TX_START_OUT <= 1'b1;
              USB_TX_ISO_OUT <= 1'b1;
              USB_TX_LOWSPEED_OUT <= 1'b0;
              // Byte count capped at the per-endpoint limit
              USB_TX_LEN_OUT <= (iso_bytes_r[iso_sel_r] > 16'h03FF) ? 10'h3FF
                                : iso_bytes_r[iso_sel_r][9:0];
              st_r <= ST_ISO_WAIT;
            end else begin
              st_r <= ST_IDLE;
            end
          end else if (st_r == ST_SCAN) begin
            if (desc_idx_r == desc_cnt_r) begin
              desc_idx_r <= '0;
              any_active_r <= 1'b0;
              if (!any_active_r || frame_cnt_r <= need_time) st_r <= ST_IDLE;
            end else if (!d0[hfbs_pkg::DESC_ACTIVE_BIT]) begin
              desc_idx_r <= desc_idx_r + 1'b1;
            end else if (frame_cnt_r > need_time) begin
              any_active_r <= 1'b1;
              pkt_len_r <= need_len;
              USB_TX_START_OUT <= 1'b1;
              USB_TX_ISO_OUT <= 1'b0;
              USB_TX_LOWSPEED_OUT <= d1[hfbs_pkg::DESC_LS_BIT];
              USB_TX_LEN_OUT <= need_len;
              st_r <= ST_PKT_WAIT;
            end else begin
              any_active_r <= 1'b1;
              desc_idx_r <= desc_idx_r + 1'b1;
            end
          end else if (async_run_r && async_full_r && !async_done_r && desc_cnt_r != '0) begin
            st_r <= ST_SCAN;
          end
        end
        ST_ISO_WAIT: if (USB_TX_DONE_IN) st_r <= async_run_r ? ST_SCAN : ST_IDLE;
        ST_PKT_WAIT: begin
          if (USB_TX_DONE_IN) begin
            desc_idx_r <= desc_idx_r + 1'b1;
            st_r <= ST_SCAN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      SOF_OUT <= 1'b0;
      INTERNAL_PULLDOWN_SEL_OUT <= 1'b0;
    end else begin
      SOF_OUT <= sof;
      INTERNAL_PULLDOWN_SEL_OUT <= hw_cfg_r[hfbs_pkg::HWC_PULLDOWN_BIT];
    end
  end

  assign LINK.rdata = rdata_r;
endmodule // hfbs_device

// ==== shared/hfbs_pkg.sv ====
// Constants shared by the frame scheduler device end and the host-driver end.
// Assumes one 100 MHz clock; the two ends meet through hfbs_if.
// What this block does
// - Write command equals read command plus bit 7
// - Packet-size fields gate packet starts near frame end
// - Isochronous irq flag set with start of frame
// - Async irq flag follows isochronous one
// - Active bit clears on completion or fatal error
// - Rescan still-active descriptors while time remains
// - Isochronous buffer write sets its full flag
// - Processed isochronous buffer gets done flag
// - Buffer read clears flags within one frame
// - Host refuses isochronous port writes only when both buffers full
// - Full and done appear together at frame start
// - One-word read clears full and done
// - Unread done clears, full sticks until reset
// - Busy async writer skips that frame's async
// - Late isochronous write suppresses async irq
// - Control phases go in separate async lists
// - At most 1023 bytes per endpoint frame
// - Pull-down select bit, cleared by reset
// - Host services interrupts every millisecond
// - Async done flag after list processed
// - Async irq bit set after list processed
// - Frame start swaps buffers; both full selects pong buffer
// - Word access moves two bytes, low even
// - Pointer reaching count raises end-of-transfer
package hfbs_pkg;
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [6:0] IDX_CONTROL = 7'h01;
  localparam logic [6:0] IDX_FRAME_INTERVAL = 7'h0D;
  localparam logic [6:0] IDX_LS_THRESHOLD = 7'h11;
  localparam logic [6:0] IDX_HW_CONFIG = 7'h20;
  localparam logic [6:0] IDX_TRANSFER_COUNT = 7'h22;
  localparam logic [6:0] IDX_IRQ_FLAGS = 7'h24;
  localparam logic [6:0] IDX_SOFT_RESET = 7'h29;
  localparam logic [6:0] IDX_ISO_LENGTH = 7'h2A;
  localparam logic [6:0] IDX_ASYNC_LENGTH = 7'h2B;
  localparam logic [6:0] IDX_BUFFER_FLAGS = 7'h2C;
  localparam logic [6:0] IDX_ISO_PORT = 7'h40;
  localparam logic [6:0] IDX_ASYNC_PORT = 7'h41;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h00F6;
  localparam int CTRL_FUNC_LO = 6;
  localparam logic [1:0] FUNC_OPERATIONAL = 2'h2;
  localparam int FS_FIELD_HI = 30;
  localparam int FS_FIELD_LO = 16;
  localparam int LS_FIELD_HI = 11;
  localparam int HWC_PULLDOWN_BIT = 12;
  localparam int IRQ_ISO_BIT = 0;
  localparam int IRQ_ASYNC_BIT = 1;
  localparam int IRQ_EOT_BIT = 2;
  localparam int BUF_PING_FULL = 0;
  localparam int BUF_PONG_FULL = 1;
  localparam int BUF_ASYNC_FULL = 2;
  localparam int BUF_PING_DONE = 3;
  localparam int BUF_PONG_DONE = 4;
  localparam int BUF_ASYNC_DONE = 5;
  localparam int DESC_ACTIVE_BIT = 15;
  localparam int DESC_LS_BIT = 15;
  localparam int BYTES_W = 10;
  localparam int BUF_WORDS = 1024;
  localparam int FRAME_TIME_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_CYCLES = FRAME_TIME_NS / CLK_PERIOD_NS;

  function automatic logic [7:0] cmd_code(input logic [6:0] idx, input logic wr);
    return {wr, idx};
  endfunction
endpackage

// ==== shared/hfbs_if.sv ====
// Command/data port between the host-driver end and the scheduler device end.
// Both ends run on the same clock; all signals change right after a rising edge.
`timescale 1ns/1ps
interface hfbs_if;
  logic cmd_we;
  logic dat_we;
  logic dat_re;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport dev (input cmd_we, input dat_we, input dat_re, input wdata, output rdata);
  modport host (output cmd_we, output dat_we, output dat_re, output wdata, input rdata);
endinterface

// ==== logic/hfbs_host.sv ====
// Host-driver end: turns user command/data requests into port cycles, restores
// the pull-down selection after reset and watches isochronous service time.
`timescale 1ns/1ps
module hfbs_host #(
  parameter int FRAME_CYCLES = hfbs_pkg::FRAME_CYCLES
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  hfbs_if.host LINK,
  input wire logic PULLDOWN_SEL_IN,
  input wire logic REQ_CMD_IN,
  input wire logic REQ_DATA_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [6:0] REQ_INDEX_IN,
  input wire logic [15:0] REQ_WDATA_IN,
  output logic [15:0] RDATA_OUT,
  output logic RDATA_VALID_OUT,
  output logic REFUSED_OUT,
  output logic BUSY_OUT,
  output logic SERVICE_LATE_OUT
);
  typedef enum logic [1:0] {HS_CFG_CMD, HS_CFG_DATA, HS_RUN} hfbs_hstate_e;
  hfbs_hstate_e hs_r;
  logic [7:0] cur_cmd_r;
  logic rd_pend_r;
  logic [1:0] shadow_full_r;
  logic [1:0] shadow_done_r;
  logic [31:0] late_cnt_r;
  logic refuse;
  logic cmd_ok;

  // Both buffers full means the port points at a full buffer
  assign refuse = REQ_CMD_IN && REQ_WRITE_IN && REQ_INDEX_IN == hfbs_pkg::IDX_ISO_PORT
                  && (&shadow_full_r);
  assign cmd_ok = hs_r == HS_RUN && !refuse;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      hs_r <= HS_CFG_CMD;
      cur_cmd_r <= 8'h0;
      rd_pend_r <= 1'b0;
      LINK.cmd_we <= 1'b0;
      LINK.dat_we <= 1'b0;
      LINK.dat_re <= 1'b0;
      LINK.wdata <= 16'h0;
      REFUSED_OUT <= 1'b0;
      BUSY_OUT <= 1'b1;
    end else begin
      LINK.cmd_we <= 1'b0;
      LINK.dat_we <= 1'b0;
      LINK.dat_re <= 1'b0;
      REFUSED_OUT <= (REQ_CMD_IN || REQ_DATA_IN) && !cmd_ok;
      rd_pend_r <= LINK.dat_re;
      unique case (hs_r)
        HS_CFG_CMD: begin
          LINK.cmd_we <= 1'b1;
          LINK.wdata <= {8'h0, hfbs_pkg::cmd_code(hfbs_pkg::IDX_HW_CONFIG, 1'b1)};
          cur_cmd_r <= hfbs_pkg::cmd_code(hfbs_pkg::IDX_HW_CONFIG, 1'b1);
          hs_r <= HS_CFG_DATA;
        end
        HS_CFG_DATA: begin
          LINK.dat_we <= 1'b1;
          LINK.wdata <= 16'(PULLDOWN_SEL_IN) << hfbs_pkg::HWC_PULLDOWN_BIT;
          BUSY_OUT <= 1'b0;
          hs_r <= HS_RUN;
        end
        HS_RUN: begin
          if (REQ_CMD_IN && cmd_ok) begin
            LINK.cmd_we <= 1'b1;
            LINK.wdata <= {8'h0, hfbs_pkg::cmd_code(REQ_INDEX_IN, REQ_WRITE_IN)};
            cur_cmd_r <= hfbs_pkg::cmd_code(REQ_INDEX_IN, REQ_WRITE_IN);
          end else if (REQ_DATA_IN) begin
            LINK.dat_we <= REQ_WRITE_IN;
            LINK.dat_re <= !REQ_WRITE_IN;
            LINK.wdata <= REQ_WDATA_IN;
          end
        end
      endcase
    end
  end

  // Read data and shadow of the buffer flags
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 16'h0;
      RDATA_VALID_OUT <= 1'b0;
      shadow_full_r <= 2'h0;
      shadow_done_r <= 2'h0;
    end else begin
      RDATA_VALID_OUT <= rd_pend_r;
      if (rd_pend_r) begin
        RDATA_OUT <= LINK.rdata;
        if (cur_cmd_r[6:0] == hfbs_pkg::IDX_BUFFER_FLAGS) begin
          shadow_full_r <= LINK.rdata[hfbs_pkg::BUF_PONG_FULL:hfbs_pkg::BUF_PING_FULL];
          shadow_done_r <= LINK.rdata[hfbs_pkg::BUF_PONG_DONE:hfbs_pkg::BUF_PING_DONE];
        end
      end
      if (LINK.dat_re && cur_cmd_r[6:0] == hfbs_pkg::IDX_ISO_PORT) shadow_done_r <= 2'h0;
    end
  end

  // Seen done flag must be answered by a buffer read within one frame
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      late_cnt_r <= 32'h0;
      SERVICE_LATE_OUT <= 1'b0;
    end else if (shadow_done_r == 2'h0) begin
      late_cnt_r <= 32'h0;
    end else if (late_cnt_r == 32'(FRAME_CYCLES - 1)) begin
      SERVICE_LATE_OUT <= 1'b1;
    end else begin
      late_cnt_r <= late_cnt_r + 32'h1;
    end
  end
endmodule // hfbs_host

// ==== tb/hfbs_port_props.sv ====
// Checker on the command/data port between the host-driver end and device end.
// Assumes one clock and is instantiated by the bench beside the interface.
`timescale 1ns/1ps
module hfbs_port_props (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic cmd_we,
  input wire logic dat_we,
  input wire logic dat_re,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  logic [7:0] cmd_r;
  logic hwc_r;
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) cmd_r <= 8'h00;
    else if (cmd_we) cmd_r <= wdata[7:0];
  end
  // Shadow of the pull-down select; a soft reset would need clearing here too
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) hwc_r <= 1'b0;
    else if (dat_we && cmd_r == 8'hA0) hwc_r <= wdata[12];
  end
  default clocking @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  sequence s_cfg_cmd;
    cmd_we && wdata[7:0] == 8'hA0;
  endsequence
  sequence s_cfg_data;
    dat_we && !cmd_we;
  endsequence
  a_reset_config: assert property ($fell(RST_IN) |-> ##[0:2] s_cfg_cmd ##1 s_cfg_data)
    else $error("pull-down restore missing after reset");
  a_pulldown_read: assert property (dat_re && cmd_r == 8'h20 |=> rdata[12] == hwc_r)
    else $error("pull-down select read back wrong");
  a_refused_read: assert property (dat_re && cmd_r[7] |=> rdata == 16'h0000)
    else $error("read under a write code returned data");
  a_unmapped_zero: assert property (dat_re && cmd_r == 8'h7F |=> rdata == 16'h0000)
    else $error("unmapped read returned data");
  a_flags_spare: assert property (dat_re && cmd_r == 8'h2C |=> rdata[15:6] == 10'h000)
    else $error("spare buffer flag bits set");
  a_one_strobe: assert property ($onehot0({cmd_we, dat_we, dat_re}))
    else $error("two port strobes at once");
  a_rdata_holds: assert property (!$past(dat_re) |-> $stable(rdata))
    else $error("read data moved without a read");
  a_data_after_cmd: assert property (dat_we || dat_re |-> cmd_r != 8'h00)
    else $error("data access before any command");
endmodule // hfbs_port_props

// ==== tb/test_host_frame_buffer_scheduler.sv ====
// Bench joining the host-driver end and the device end through hfbs_if.
// Assumes a short frame; a stub packet engine answers each packet start.
`timescale 1ns/1ps
module test_host_frame_buffer_scheduler;
  localparam int FC = 200;
  logic clk, rst, psel, rcmd, rdat, rwr, start, iso, sof, pd, rv, busy, late;
  logic done_in = 1'b0;
  logic [6:0] ridx;
  logic [15:0] rwd, rd_v, v;
  logic [9:0] tx_len, iso_len_seen;
  logic [2:0] dly = 3'h0;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_async = 0;
  int b;
  hfbs_if link ();
  hfbs_device #(.FRAME_CYCLES(FC)) i_hfbs_device (.CORE_CLK_IN(clk), .RST_IN(rst),
    .LINK(link.dev), .USB_TX_DONE_IN(done_in), .USB_TX_ERR_IN(1'b0), .USB_TX_START_OUT(start),
    .USB_TX_ISO_OUT(iso), .USB_TX_LOWSPEED_OUT(), .USB_TX_LEN_OUT(tx_len), .SOF_OUT(sof),
    .INTERNAL_PULLDOWN_SEL_OUT(pd));
  hfbs_host #(.FRAME_CYCLES(FC)) i_hfbs_host (.CORE_CLK_IN(clk), .RST_IN(rst), .LINK(link.host),
    .PULLDOWN_SEL_IN(psel), .REQ_CMD_IN(rcmd), .REQ_DATA_IN(rdat), .REQ_WRITE_IN(rwr),
    .REQ_INDEX_IN(ridx), .REQ_WDATA_IN(rwd), .RDATA_OUT(rd_v), .RDATA_VALID_OUT(rv),
    .REFUSED_OUT(), .BUSY_OUT(busy), .SERVICE_LATE_OUT(late));
  hfbs_port_props i_hfbs_port_props (.CORE_CLK_IN(clk), .RST_IN(rst), .cmd_we(link.cmd_we),
    .dat_we(link.dat_we), .dat_re(link.dat_re), .wdata(link.wdata), .rdata(link.rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Packet engine stub: one packet outstanding, done five cycles after start
  always @(posedge clk) begin
    done_in <= (dly == 3'h1);
    dly <= start ? 3'h5 : (dly != 3'h0 ? dly - 3'h1 : 3'h0);
    if (start && !iso) n_async <= n_async + 1;
    if (start && iso) iso_len_seen <= tx_len;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic req(input logic c, input logic w, input logic [6:0] idx, input logic [15:0] d);
    @(posedge clk);
    rcmd <= c;
    rdat <= !c;
    rwr <= w;
    ridx <= idx;
    rwd <= d;
    @(posedge clk);
    rcmd <= 1'b0;
    rdat <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    req(1'b1, 1'b1, idx, 16'h0000);
    req(1'b0, 1'b1, idx, d);
  endtask
  task automatic rd(input logic w, input logic [6:0] idx, output logic [15:0] q);
    int k;
    req(1'b1, w, idx, 16'h0000);
    req(1'b0, 1'b0, idx, 16'h0000);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (rv !== 1'b1 && k < 8);
    check("read answered", {15'h0000, rv}, 16'h0001);
    q = rd_v;
  endtask
  task automatic wait_sof;
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (sof !== 1'b1 && k < 2 * FC);
    check("frame start", {15'h0000, sof}, 16'h0001);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic fill_iso;
    wait_sof;
    req(1'b1, 1'b1, 7'h40, 16'h0000);
    req(1'b0, 1'b1, 7'h40, 16'h1234);
    req(1'b0, 1'b1, 7'h40, 16'h5678);
  endtask
  task automatic t_regs;
    rd(1'b0, 7'h20, v);
    check("pulldown bit", {15'h0000, v[12]}, 16'h0001);
    check("pulldown pin", {15'h0000, pd}, 16'h0001);
    check("busy after restore", {15'h0000, busy}, 16'h0000);
    rd(1'b1, 7'h20, v);
    check("read with write code", v, 16'h0000);
    rd(1'b0, 7'h7F, v);
    check("unmapped read", v, 16'h0000);
  endtask
  task automatic t_async;
    wr(7'h01, 16'h0080);
    wr(7'h22, 16'h0004);
    wait_sof;
    b = n_async;
    // One descriptor: active, four bytes, two-byte packets
    req(1'b1, 1'b1, 7'h41, 16'h0000);
    req(1'b0, 1'b1, 7'h41, 16'h8004);
    req(1'b0, 1'b1, 7'h41, 16'h0002);
    wait_sof;
    wait_sof;
    rd(1'b0, 7'h2C, v);
    check("async done", {15'h0000, v[5]}, 16'h0001);
    rd(1'b0, 7'h24, v);
    check("async irq", {15'h0000, v[1]}, 16'h0001);
    check("async packets", 16'(n_async - b), 16'h0002);
    rd(1'b0, 7'h41, v);
    check("descriptor word0", v, 16'h0000);
  endtask
  task automatic t_iso;
    wr(7'h24, 16'h0007);
    fill_iso;
    rd(1'b0, 7'h2C, v);
    check("iso full", {15'h0000, v[0] | v[1]}, 16'h0001);
    rd(1'b0, 7'h24, v);
    check("end of transfer", {15'h0000, v[2]}, 16'h0001);
    wait_sof;
    rd(1'b0, 7'h24, v);
    check("iso irq", {15'h0000, v[0]}, 16'h0001);
    check("iso packet length", {6'h00, iso_len_seen}, 16'h0004);
    wait_sof;
    rd(1'b0, 7'h2C, v);
    check("full with done", {15'h0000, (v[0] & v[3]) | (v[1] & v[4])}, 16'h0001);
    rd(1'b0, 7'h40, v);
    rd(1'b0, 7'h2C, v);
    check("flags cleared", v & 16'h001B, 16'h0000);
    check("service on time", {15'h0000, late}, 16'h0000);
  endtask
  task automatic t_stuck;
    fill_iso;
    repeat (2) wait_sof;
    rd(1'b0, 7'h2C, v);
    check("done before stuck", {15'h0000, v[3] | v[4]}, 16'h0001);
    // Host saw the done flag and never reads the buffer back
    repeat (2) wait_sof;
    check("service late", {15'h0000, late}, 16'h0001);
    rd(1'b0, 7'h2C, v);
    check("full stuck", {14'h0000, v[4:3] == 2'b00, v[1] | v[0]}, 16'h0003);
    @(posedge clk);
    psel <= 1'b0;
    do_reset;
    rd(1'b0, 7'h2C, v);
    check("flags after reset", v, 16'h0000);
    rd(1'b0, 7'h20, v);
    check("pulldown cleared", {15'h0000, v[12]}, 16'h0000);
    check("pulldown pin low", {15'h0000, pd}, 16'h0000);
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b1;
    rcmd = 1'b0;
    rdat = 1'b0;
    rwr = 1'b0;
    ridx = 7'h00;
    rwd = 16'h0000;
    do_reset;
    t_regs;
    t_async;
    t_iso;
    t_stuck;
    stop_test();
  end
endmodule // test_host_frame_buffer_scheduler
